/* File: srwe_map.svh */
`ifndef SRWE_MAP_SVH
`define SRWE_MAP_SVH

// fixed upper nibble of the device address byte
`define SRWE_DEV_CODE     4'ha
// word address and page geometry
`define SRWE_ADDR_W       14
`define SRWE_PAGE_W       6
// bit slot numbers counted in rising scl edges since the byte began
`define SRWE_ACK_SLOT     4'h8
`define SRWE_ACK_END      4'h9
// reset values
`define SRWE_RST_STATE    3'h0
// program cycle timing
`define SRWE_PROG_TIME_MS 5
`define SRWE_CLK_HZ       100000000
// longest time rounds down, so plain integer division
`define SRWE_PROG_CYCLES  (`SRWE_PROG_TIME_MS * (`SRWE_CLK_HZ / 1000))

`endif

/* File: srwe_pkg.sv */
`default_nettype none
package srwe_pkg;

  // gray along idle -> dev -> addr hi -> addr lo -> write -> read
  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_DEV    = 3'h1,
    S_ADDRHI = 3'h3,
    S_ADDRLO = 3'h2,
    S_WRITE  = 3'h6,
    S_READ   = 3'h7,
    S_IGNORE = 3'h5
  } srwe_state_t;

endpackage
`default_nettype wire

/* File: srwe_nvm.sv */
`include "srwe_map.svh"
`default_nettype none
module srwe_nvm #(
  parameter int ADDR_W      = `SRWE_ADDR_W,
  parameter int PAGE_W      = `SRWE_PAGE_W,
  parameter int PROG_CYCLES = `SRWE_PROG_CYCLES
) (
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic                              clkEn,
  input  wire logic                              commitGo,
  input  wire logic [ADDR_W-PAGE_W-1:0]          commitRow,
  input  wire logic [(1<<PAGE_W)-1:0][7:0]       commitData,
  input  wire logic [(1<<PAGE_W)-1:0]            commitMask,
  input  wire logic [ADDR_W-1:0]                 readAddr,
  output logic      [7:0]                        readData,
  output logic                                   busy
);
  import srwe_pkg::*;

  localparam int PAGE_BYTES = 1 << PAGE_W;
  localparam int DEPTH      = 1 << ADDR_W;
  localparam int TW         = $clog2(PROG_CYCLES + 1);
  localparam logic [TW-1:0] LAST_TICK = TW'(PROG_CYCLES - 1);

  typedef struct packed {
    logic [DEPTH-1:0][7:0]           mem;
    logic [ADDR_W-PAGE_W-1:0]        row;
    logic [PAGE_BYTES-1:0][7:0]      data;
    logic [PAGE_BYTES-1:0]           mask;
    logic [TW-1:0]                   timer;
    logic                            busy;
  } srwe_nvm_t;

  srwe_nvm_t q;
  srwe_nvm_t n;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    if (q.busy) begin
      n.timer = q.timer + TW'(1);
      if (q.timer == LAST_TICK) begin
        // whole page lands at once, only bytes that were received
        for (int i = 0; i < PAGE_BYTES; i++) begin
          if (q.mask[i]) begin
            n.mem[{q.row, PAGE_W'(i)}] = q.data[i];
          end
        end
        n.busy = 1'b0;
      end
    end else if (commitGo) begin
      n.row   = commitRow;
      n.data  = commitData;
      n.mask  = commitMask;
      n.timer = '0;
      n.busy  = 1'b1;
    end
  end

  // array keeps its contents over reset, it stands for nonvolatile cells
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q.busy  <= 1'b0;
      q.timer <= '0;
      q.mask  <= '0;
      q.row   <= '0;
      q.data  <= '0;
    end else if (clkEn) begin
      q <= n;
    end
  end

  assign readData = q.mem[readAddr];
  assign busy     = q.busy;

  ////////////////////////////////////////////////////////////////////////////
  a_prog_length: assert property (@(posedge clk)
    disable iff (!rst_b || !clkEn)
    $rose(q.busy) |-> q.busy [*8])
    else $error("program cycle ended too early");

endmodule
`default_nettype wire

/* File: srwe_engine.sv */
// What this block does
// - after device address, two word address bytes each get a low acknowledge
// - stop ending a write starts timed programming; bus ignored until done
// - programming completes within five milliseconds
// - up to 64 bytes buffered and programmed together in one cycle
// - every received write data byte is acknowledged low in ninth clock
// - write bytes step only low 6 address bits; page row kept
// - beyond 64 bytes the page wraps and later bytes overwrite earlier
// - while programming, start plus device address stays unacknowledged
// - write protect high inhibits all programming; reads still work
// - address counter holds last address plus one across transfers
// - reading past the last byte wraps counter to address zero
// - read direction address acknowledged, then current byte sent msb first
// - master acknowledge steps counter and sends next byte, wrapping
// - nack plus stop ends read; device releases data line, standby
// - first byte is 1010, three select bits, then read high direction
// - select bits compared with straps; mismatch returns to standby silently
// - word address is 14 bits wide
`include "srwe_map.svh"
`default_nettype none
module srwe_engine #(
  parameter int ADDR_W      = `SRWE_ADDR_W,
  parameter int PAGE_W      = `SRWE_PAGE_W,
  parameter int PROG_CYCLES = `SRWE_PROG_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       clkEn,
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic [2:0] chipSelectStraps,
  input  wire logic       writeProtect,
  output logic            progBusy
);
  import srwe_pkg::*;

  localparam int PAGE_BYTES = 1 << PAGE_W;
  localparam int ROW_W      = ADDR_W - PAGE_W;

  typedef struct packed {
    logic [2:0]                 sclSy;
    logic [2:0]                 sdaSy;
    logic [1:0]                 wpSy;
    logic [1:0][2:0]            csSy;
    srwe_state_t                state;
    logic [3:0]                 bitCnt;
    logic [7:0]                 rx;
    logic [7:0]                 tx;
    logic                       readMode;
    logic                       masterAck;
    logic [ADDR_W-9:0]          addrHi;
    logic [ADDR_W-1:0]          addr;
    logic [PAGE_BYTES-1:0][7:0] pageBuf;
    logic [PAGE_BYTES-1:0]      pageMask;
    logic                       hasData;
    logic                       drive;
    logic                       commitGo;
  } srwe_eng_t;

  srwe_eng_t q;
  srwe_eng_t n;

  logic       sclBit_q;
  logic       riseEv;
  logic       fallEv;
  logic       startEv;
  logic       stopEv;
  logic       sclHigh;
  logic       csMatch;
  logic       nvmBusy;
  logic [7:0] rdData;

  ////////////////////////////////////////////////////////////////////////////
  // link side: the bit is caught on the master's own rising edge; sda is
  // stable while scl is high, and the core reads it only after seeing the
  // synchronised rise, so it has been settled for at least two clk cycles
  always_ff @(posedge scl) begin
    sclBit_q <= sdaIn;
  end

  ////////////////////////////////////////////////////////////////////////////
  // edges are taken from the second and third stages only
  assign sclHigh = q.sclSy[1];
  assign riseEv  = q.sclSy[1] & ~q.sclSy[2];
  assign fallEv  = ~q.sclSy[1] & q.sclSy[2];
  assign startEv = sclHigh & q.sclSy[2] & ~q.sdaSy[1] & q.sdaSy[2];
  assign stopEv  = sclHigh & q.sclSy[2] & q.sdaSy[1] & ~q.sdaSy[2];
  assign csMatch = (q.rx[7:4] == `SRWE_DEV_CODE) &&
                   (q.rx[3:1] == q.csSy[1]);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n          = q;
    n.sclSy    = {q.sclSy[1:0], scl};
    n.sdaSy    = {q.sdaSy[1:0], sdaIn};
    n.wpSy     = {q.wpSy[0], writeProtect};
    n.csSy     = {q.csSy[0], chipSelectStraps};
    n.commitGo = 1'b0;
    if (nvmBusy) begin
      // deaf during programming, so polls go unanswered
      n.state  = S_IDLE;
      n.drive  = 1'b0;
      n.bitCnt = '0;
    end else if (startEv) begin
      // a repeated start drops any page not closed by a stop
      n.state    = S_DEV;
      n.bitCnt   = '0;
      n.drive    = 1'b0;
      n.pageMask = '0;
      n.hasData  = 1'b0;
    end else if (stopEv) begin
      if (q.state == S_WRITE && q.hasData && !q.wpSy[1]) begin
        n.commitGo = 1'b1;
      end
      n.state = S_IDLE;
      n.drive = 1'b0;
    end else if (q.state == S_IDLE || q.state == S_IGNORE) begin
      n.drive = 1'b0;
    end else if (riseEv) begin
      if (q.bitCnt < `SRWE_ACK_SLOT) begin
        n.rx = {q.rx[6:0], sclBit_q};
      end else if (q.bitCnt == `SRWE_ACK_SLOT) begin
        n.masterAck = ~sclBit_q;
      end
      if (q.bitCnt < `SRWE_ACK_END) begin
        n.bitCnt = q.bitCnt + 4'h1;
      end
    end else if (fallEv) begin
      if (q.bitCnt == `SRWE_ACK_SLOT) begin
        case (q.state)
          S_DEV: begin
            if (csMatch) begin
              n.drive    = 1'b1;
              n.readMode = q.rx[0];
            end else begin
              n.state = S_IGNORE;
              n.drive = 1'b0;
            end
          end
          S_ADDRHI: begin
            n.addrHi = q.rx[ADDR_W-9:0];
            n.drive  = 1'b1;
          end
          S_ADDRLO: begin
            n.addr  = {q.addrHi, q.rx};
            n.drive = 1'b1;
          end
          S_WRITE: begin
            // same slot reused after a wrap, so later bytes win
            n.pageBuf[q.addr[PAGE_W-1:0]]  = q.rx;
            n.pageMask[q.addr[PAGE_W-1:0]] = 1'b1;
            n.hasData = 1'b1;
            n.addr[PAGE_W-1:0] = q.addr[PAGE_W-1:0] + PAGE_W'(1);
            n.drive   = 1'b1;
          end
          default: begin
            // read: let go so the master can answer
            n.drive = 1'b0;
          end
        endcase
      end else if (q.bitCnt == `SRWE_ACK_END) begin
        n.bitCnt = '0;
        n.drive  = 1'b0;
        case (q.state)
          S_DEV: begin
            if (q.readMode) begin
              n.state = S_READ;
              n.tx    = rdData;
              n.drive = ~rdData[7];
              n.addr  = q.addr + ADDR_W'(1);
            end else begin
              n.state = S_ADDRHI;
            end
          end
          S_ADDRHI: begin
            n.state = S_ADDRLO;
          end
          S_ADDRLO: begin
            n.state = S_WRITE;
          end
          S_READ: begin
            if (q.masterAck) begin
              n.tx    = rdData;
              n.drive = ~rdData[7];
              n.addr  = q.addr + ADDR_W'(1);
            end else begin
              n.state = S_IGNORE;
            end
          end
          default: begin
            n.state = q.state;
          end
        endcase
      end else if (q.state == S_READ && q.bitCnt != 4'h0) begin
        n.tx    = {q.tx[6:0], 1'b0};
        n.drive = ~q.tx[6];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q       <= '0;
      // pins rest high; a cleared chain would show a false rise after reset
      q.sclSy <= 3'h7;
      q.sdaSy <= 3'h7;
    end else if (clkEn) begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  srwe_nvm #(
    .ADDR_W      (ADDR_W),
    .PAGE_W      (PAGE_W),
    .PROG_CYCLES (PROG_CYCLES)
  ) u_nvm (
    .clk        (clk),
    .rst_b      (rst_b),
    .clkEn      (clkEn),
    .commitGo   (q.commitGo),
    .commitRow  (q.addr[ADDR_W-1:PAGE_W]),
    .commitData (q.pageBuf),
    .commitMask (q.pageMask),
    .readAddr   (q.addr),
    .readData   (rdData),
    .busy       (nvmBusy)
  );

  // only ever pulls low; the pin is released otherwise
  assign sdaOut   = 1'b0;
  assign sdaOe    = q.drive;
  assign progBusy = nvmBusy;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] busyCnt_q;

  always_ff @(posedge clk) begin
    if (!rst_b || !nvmBusy) begin
      busyCnt_q <= '0;
    end else if (clkEn) begin
      busyCnt_q <= busyCnt_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !clkEn);

  a_busy_silent: assert property (nvmBusy |=> !sdaOe)
    else $error("bus driven during program cycle");
  a_busy_idle: assert property (nvmBusy |=> q.state == S_IDLE)
    else $error("engine active during program cycle");
  a_stop_commit: assert property (
    (stopEv && !nvmBusy && !startEv && q.state == S_WRITE && q.hasData &&
     !q.wpSy[1]) |-> ##2 nvmBusy)
    else $error("write stop did not start programming");
  a_prog_bound: assert property (busyCnt_q <= PROG_CYCLES)
    else $error("program cycle too long");
  a_wp_inhibit: assert property (
    $rose(nvmBusy) |-> !$past(q.wpSy[1], 2))
    else $error("programming under write protect");
  a_addr_ack: assert property (
    (fallEv && !nvmBusy && !startEv && !stopEv &&
     q.bitCnt == `SRWE_ACK_SLOT &&
     (q.state == S_ADDRHI || q.state == S_ADDRLO || q.state == S_WRITE))
    |=> sdaOe && !sdaOut)
    else $error("address or data byte not acknowledged");
  a_dev_mismatch: assert property (
    (fallEv && !nvmBusy && !startEv && !stopEv &&
     q.bitCnt == `SRWE_ACK_SLOT && q.state == S_DEV && !csMatch)
    |=> !sdaOe && q.state == S_IGNORE)
    else $error("foreign address acknowledged");
  a_page_step: assert property (
    (fallEv && !nvmBusy && !startEv && !stopEv &&
     q.bitCnt == `SRWE_ACK_SLOT && q.state == S_WRITE)
    |=> q.addr[ADDR_W-1:PAGE_W] == $past(q.addr[ADDR_W-1:PAGE_W]) &&
        q.addr[PAGE_W-1:0] == $past(q.addr[PAGE_W-1:0]) + PAGE_W'(1))
    else $error("write address left its page");
  a_read_step: assert property (
    (fallEv && !nvmBusy && !startEv && !stopEv &&
     q.bitCnt == `SRWE_ACK_END &&
     ((q.state == S_DEV && q.readMode) || (q.state == S_READ && q.masterAck)))
    |=> q.addr == $past(q.addr) + ADDR_W'(1) && q.tx == $past(rdData))
    else $error("read counter did not step");
  a_nack_release: assert property (
    (fallEv && !nvmBusy && !startEv && !stopEv &&
     q.bitCnt == `SRWE_ACK_END && q.state == S_READ && !q.masterAck)
    |=> !sdaOe [*3])
    else $error("line held after master nack");

  ////////////////////////////////////////////////////////////////////////////
  // framing: start and stop override any byte in flight
  a_start_dev: assert property (
    (startEv && !nvmBusy) |=> q.state == S_DEV && !sdaOe)
    else $error("start did not open a device address");
  a_stop_standby: assert property (
    (stopEv && !nvmBusy) |=> q.state == S_IDLE && !sdaOe)
    else $error("stop did not return to standby");
  a_wp_no_commit: assert property (
    (stopEv && !nvmBusy && q.wpSy[1]) |=> !q.commitGo)
    else $error("commit issued under write protect");
  a_dev_ack: assert property (
    (fallEv && !nvmBusy && !startEv && !stopEv &&
     q.bitCnt == `SRWE_ACK_SLOT && q.state == S_DEV && csMatch)
    |=> sdaOe)
    else $error("matching device address not acknowledged");
  // master owns the ninth slot of a read byte
  a_read_release: assert property (
    (fallEv && !nvmBusy && !startEv && !stopEv &&
     q.bitCnt == `SRWE_ACK_SLOT && q.state == S_READ)
    |=> !sdaOe)
    else $error("line held in master acknowledge slot");

  c_page_commit: cover property (
    q.commitGo && q.pageMask == {PAGE_BYTES{1'b1}});
  c_seq_read: cover property (
    fallEv && q.state == S_READ && q.masterAck &&
    q.bitCnt == `SRWE_ACK_END);
  c_poll_nack: cover property (nvmBusy && startEv);
  c_cs_miss: cover property (q.state == S_IGNORE);
  c_array_wrap: cover property (q.state == S_READ && q.addr == '0);

endmodule
`default_nettype wire

/* File: srwe_master.sv */
`default_nettype none
module srwe_master (
  output var logic scl,
  output var logic sda,
  input  wire logic sdaIn
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // sda only moves while scl is low; sampled mid high
  task automatic slot(input logic b, output logic seen);
    scl = 1'b0;
    #20 sda = b;
    #20 scl = 1'b1;
    #20 seen = sdaIn;
    #20;
  endtask
  // scl rests high between frames; a repeated start waits out the ack
  task automatic start();
    if (!(scl && sdaIn)) begin
      scl = 1'b0;
      #40 sda = 1'b1;
      #20 scl = 1'b1;
      #40;
    end
    sda = 1'b0;
    #40;
  endtask
  task automatic stop();
    scl = 1'b0;
    #40 sda = 1'b0;
    #20 scl = 1'b1;
    #40 sda = 1'b1;
    #40;
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(b[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask
  task automatic recvByte(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, s);
      d[i] = s;
    end
    slot(~ackIt, s);
  endtask
endmodule
`default_nettype wire

/* File: serial_eeprom_read_write_engine_tb.sv */
`default_nettype none
module serial_eeprom_read_write_engine_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PROG = 200;
  localparam logic [7:0] DEV_W = 8'haa;
  localparam logic [7:0] DEV_R = 8'hab;
  logic        clk, rst_b, scl, mSda, sdaWire, sdaOut, sdaOe;
  logic        progBusy, wp, ack;
  logic [2:0]  straps;
  logic [13:0] cnt;
  logic [7:0]  model [16384];
  int          errors, check_count, cycles, busyCnt;

  // open drain wire with pull-up
  assign sdaWire = (sdaOe ? sdaOut : 1'b1) & mSda;

  srwe_engine #(.PROG_CYCLES(PROG)) srwe_engine_inst (
    .clk(clk), .rst_b(rst_b), .clkEn(1'b1), .scl(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectStraps(straps),
    .writeProtect(wp), .progBusy(progBusy));
  srwe_master srwe_master_inst (.scl(scl), .sda(mSda), .sdaIn(sdaWire));

  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (progBusy) busyCnt++;
    if (cycles == 30000) begin
      errors++;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic exp, input string w);
    srwe_master_inst.sendByte(b, ack);
    chk(w, 16'(ack), 16'(exp));
  endtask
  task automatic setAddr(input logic [15:0] a);
    srwe_master_inst.start();
    send(DEV_W, 1'b1, "dev write");
    send(a[15:8], 1'b1, "addr hi");
    send(a[7:0], 1'b1, "addr lo");
    cnt = a[13:0];
  endtask
  // a start during programming is dropped, so poll until acknowledged
  task automatic poll();
    int nacks;
    nacks = 0;
    ack = 1'b0;
    while (!ack && nacks < 20) begin
      srwe_master_inst.start();
      srwe_master_inst.sendByte(DEV_W, ack);
      srwe_master_inst.stop();
      if (!ack) nacks++;
    end
    chk("poll ack", 16'(ack), 16'h1);
    chk("nack while busy", 16'(nacks > 0), 16'h1);
  endtask
  task automatic writeBurst(input logic [15:0] a, input int n,
                            input logic [7:0] base);
    logic [7:0] d;
    busyCnt = 0;
    setAddr(a);
    for (int i = 0; i < n; i++) begin
      d = base + 8'(i);
      send(d, 1'b1, "data ack");
      if (!wp) model[cnt] = d;
      cnt[5:0] = cnt[5:0] + 6'h1;
    end
    srwe_master_inst.stop();
    repeat (5) @(posedge clk);
    chk("busy", 16'(progBusy), 16'(!wp));
    if (!wp) poll();
    chk("busy cycles", 16'(busyCnt), wp ? 16'h0 : 16'(PROG));
  endtask
  task automatic readBytes(input int n);
    logic [7:0] d;
    srwe_master_inst.start();
    send(DEV_R, 1'b1, "dev read");
    for (int i = 0; i < n; i++) begin
      srwe_master_inst.recvByte(i < n - 1, d);
      chk("read data", 16'(d), 16'(model[cnt]));
      cnt = cnt + 14'h1;
    end
    srwe_master_inst.stop();
    @(posedge clk);
    chk("released", {14'h0, sdaOe, sdaOut}, 16'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_page();
    writeBurst(16'h003e, 66, 8'h10);
    readBytes(2);
    $display("test page write done");
  endtask
  task automatic t_wrap();
    writeBurst(16'hffff, 1, 8'h5a);
    setAddr(16'hbfff);
    readBytes(3);
    $display("test array wrap done");
  endtask
  task automatic t_protect();
    @(negedge clk) wp = 1'b1;
    repeat (4) @(negedge clk);
    writeBurst(16'h0001, 2, 8'hc3);
    @(negedge clk) wp = 1'b0;
    setAddr(16'h0001);
    readBytes(2);
    $display("test write protect done");
  endtask
  task automatic t_foreign();
    logic [7:0] bad [3] = '{8'ha8, 8'hae, 8'h2a};
    foreach (bad[i]) begin
      srwe_master_inst.start();
      send(bad[i], 1'b0, "foreign ack");
      srwe_master_inst.stop();
    end
    @(negedge clk) straps = 3'h2;
    repeat (4) @(negedge clk);
    srwe_master_inst.start();
    send(DEV_W, 1'b0, "old straps");
    srwe_master_inst.stop();
    srwe_master_inst.start();
    send(8'ha4, 1'b1, "new straps");
    srwe_master_inst.stop();
    @(negedge clk) straps = 3'h5;
    repeat (4) @(negedge clk);
    $display("test chip select done");
  endtask

  initial begin
    rst_b = 1'b0;
    wp = 1'b0;
    straps = 3'h5;
    errors = 0;
    check_count = 0;
    cycles = 0;
    busyCnt = 0;
    repeat (4) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    repeat (7) @(negedge clk);
    #3;
    t_page();
    t_wrap();
    t_protect();
    t_foreign();
    final_report();
  end
endmodule
`default_nettype wire
